// *** include/mqu_consts.vh ***
// constants of the message queue unit: register offsets, fields, reset values, window offsets
// assumes 32-bit apb data, one register per aligned word, byte addresses
`ifndef MQU_CONSTS_VH
`define MQU_CONSTS_VH
`define MQU_REG_CTRL 12'h000
`define MQU_REG_MISC 12'h004
`define MQU_REG_INTEN 12'h008
`define MQU_REG_INTST 12'h00C
`define MQU_REG_XLATE 12'h010
`define MQU_REG_PTR0 12'h020
`define MQU_REG_PTR_LAST 12'h03C
`define MQU_CTRL_EN_BIT 0
`define MQU_CTRL_SIZE_LSB 1
`define MQU_CTRL_EMPTY_LSB 4
`define MQU_CTRL_FULL_LSB 8
`define MQU_CTRL_BASE_LSB 20
`define MQU_MISC_DIS_BIT 0
`define MQU_INT_IN_BIT 0
`define MQU_INT_OUT_BIT 1
`define MQU_INT_DBL_BIT 2
`define MQU_INT_DBP_BIT 3
`define MQU_RST_CTRL 32'h0000_0000
`define MQU_RST_MISC 1'b1
`define MQU_RST_INTEN 4'h0
`define MQU_RST_XLATE 32'h0000_0000
`define MQU_WIN_DBL 32'h0000_0030
`define MQU_WIN_DBP 32'h0000_0034
`define MQU_WIN_INBOUND 32'h0000_0040
`define MQU_WIN_OUTBOUND 32'h0000_0044
`define MQU_WIN_UNTRANS 32'h0000_1000
`define MQU_EMPTY_WORD 32'hFFFF_FFFF
`define MQU_PTR_STEP 20'h0_0004
`define MQU_SIZE_MIN 20'h0_0400
`define MQU_CFG_BAR_FIRST 8'h10
`define MQU_CFG_BAR_THIRD 8'h18
`endif

// *** verilog/mqu_ptr_wrap.v ***
// pointer step with wrap inside a queue of programmable size
// assumes queues aligned to their own size inside the 1 Mbyte window
`timescale 1ns/1ps
`default_nettype none
`include "mqu_consts.vh"
module mqu_ptr_wrap (
  input wire [19:0] ptr,
  input wire [2:0] size_sel,
  output wire [19:0] next_ptr
);
  wire [19:0] mask;
  wire [19:0] stepped;
  // queue size is 1 Kbyte shifted by size_sel
  assign mask = (`MQU_SIZE_MIN << size_sel) - 20'h0_0001;
  assign stepped = ptr + `MQU_PTR_STEP;
  // upper bits hold the queue start, low bits count modulo the size
  assign next_ptr = (ptr & ~mask) | (stepped & mask);
endmodule // mqu_ptr_wrap
`default_nettype wire

// *** verilog/mqu_top.v ***
// message queue unit: apb registers, pci queue-port requests, local-bus master cycles
// assumes pci request and local-bus answer come from logic on pclk, so no synchronisers
`timescale 1ns/1ps
`default_nettype none
`include "mqu_consts.vh"
module mqu_top (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire pci_req,
  input wire pci_write,
  input wire [31:0] pci_addr,
  input wire [31:0] pci_wdata,
  output reg pci_ack,
  output reg [31:0] pci_rdata,
  output reg lb_req,
  output reg lb_write,
  output reg [31:0] lb_addr,
  output reg [31:0] lb_wdata,
  input wire lb_ack,
  input wire [31:0] lb_rdata,
  output reg local_irq,
  output reg pci_irq,
  output reg image0_at_first_bar,
  output reg [7:0] register_bar_offset
);
  localparam ST_IDLE = 2'b00;
  localparam ST_LBUS = 2'b01;
  localparam ST_ACK = 2'b10;
  // pointer indices: bottom of queue q is 2q, top is 2q+1
  localparam [2:0] P_IF_BOT = 3'd0;
  localparam [2:0] P_IP_TOP = 3'd3;
  localparam [2:0] P_OP_BOT = 3'd4;
  localparam [2:0] P_OF_TOP = 3'd7;
  localparam Q_IF = 0;
  localparam Q_IP = 1;
  localparam Q_OP = 2;
  localparam Q_OF = 3;

  reg [1:0] state;
  reg [1:0] next_state;
  reg queue_mode_enable;
  reg [2:0] size_sel;
  reg [11:0] queue_base_address;
  reg pci_access_disable;
  reg [3:0] int_enable;
  reg inbound_new_entry_status;
  reg doorbell_local_status;
  reg doorbell_pci_status;
  reg [31:0] image0_translation;
  reg adv_pending;
  reg [2:0] adv_idx;
  reg lb_req_start;
  reg start_adv;
  reg [2:0] start_idx;
  reg [31:0] start_addr;
  reg [31:0] start_rdata;
  wire [3:0] full;
  wire [159:0] ptr_flat;
  wire [159:0] stepped_flat;
  wire [159:0] next_ptr_flat;
  wire [7:0] ptr_upd;
  wire [3:0] empty;
  wire outbound_post_status;
  wire apb_setup;
  wire apb_wr;
  wire adv_now;
  wire [11:0] qba;

  assign apb_setup = psel & ~penable;
  // writes take effect at the access edge only
  assign apb_wr = psel & penable & pwrite & pready;
  assign adv_now = (state == ST_LBUS) & lb_ack & adv_pending;
  assign qba = queue_base_address;

  // eight pointers, each low 20 bits under the shared 1 Mbyte base
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_ptr
      reg [19:0] ptr;
      wire [19:0] stepped;
      wire sw_hit;
      wire dev_hit;
      mqu_ptr_wrap u_wrap (
        .ptr(ptr),
        .size_sel(size_sel),
        .next_ptr(stepped)
      );
      assign sw_hit = apb_wr & (paddr == `MQU_REG_PTR0 + 4 * i);
      assign dev_hit = adv_now & (adv_idx == i);
      assign ptr_upd[i] = sw_hit | dev_hit;
      // device advance wins over a software write in the same cycle
      assign next_ptr_flat[i*20 +: 20] = dev_hit ? stepped :
                                         sw_hit ? pwdata[19:0] : ptr;
      assign ptr_flat[i*20 +: 20] = ptr;
      assign stepped_flat[i*20 +: 20] = stepped;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ptr <= 20'h0_0000;
        end else begin
          ptr <= next_ptr_flat[i*20 +: 20];
        end
      end
    end
  endgenerate

  // full flag: set when a top moves one step onto the bottom, cleared by a bottom move
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_full
      wire meet;
      wire top_step;
      reg full_q;
      assign meet = next_ptr_flat[(2*i+1)*20 +: 20] == next_ptr_flat[(2*i)*20 +: 20];
      // a write making the pointers equal reads as empty unless it lands one step past the old top, which fills like a device step
      assign top_step = next_ptr_flat[(2*i+1)*20 +: 20] == stepped_flat[(2*i+1)*20 +: 20];
      assign full[i] = full_q;
      // equal pointers with no full mark read as empty, as at start-up
      assign empty[i] = ~full[i] & (ptr_flat[(2*i+1)*20 +: 20] == ptr_flat[(2*i)*20 +: 20]);
      // set wins: both pointers stepping together keeps a full queue full
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          full_q <= 1'b0;
        end else if (ptr_upd[2*i+1] & meet & top_step) begin
          full_q <= 1'b1;
        end else if (ptr_upd[2*i]) begin
          full_q <= 1'b0;
        end
      end
    end
  endgenerate

  assign outbound_post_status = ~empty[Q_OP];

  // software registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      queue_mode_enable <= 1'b0;
      size_sel <= 3'h0;
      queue_base_address <= 12'h000;
      pci_access_disable <= `MQU_RST_MISC;
      int_enable <= `MQU_RST_INTEN;
      image0_translation <= `MQU_RST_XLATE;
    end else if (apb_wr) begin
      case (paddr)
        `MQU_REG_CTRL: begin
          queue_mode_enable <= pwdata[`MQU_CTRL_EN_BIT];
          size_sel <= pwdata[`MQU_CTRL_SIZE_LSB +: 3];
          // base keeps only bits 31..20, so it is always 1 Mbyte aligned
          queue_base_address <= pwdata[31:`MQU_CTRL_BASE_LSB];
        end
        `MQU_REG_MISC: begin
          pci_access_disable <= pwdata[`MQU_MISC_DIS_BIT];
        end
        `MQU_REG_INTEN: begin
          int_enable <= pwdata[3:0];
        end
        `MQU_REG_XLATE: begin
          image0_translation <= pwdata;
        end
        default: begin
          queue_mode_enable <= queue_mode_enable;
        end
      endcase
    end
  end

  // sticky status bits; a set in the clearing cycle wins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inbound_new_entry_status <= 1'b0;
      doorbell_local_status <= 1'b0;
      doorbell_pci_status <= 1'b0;
    end else begin
      if (adv_now & (adv_idx == P_IP_TOP)) begin
        inbound_new_entry_status <= 1'b1;
      end else if (apb_wr & (paddr == `MQU_REG_INTST) & pwdata[`MQU_INT_IN_BIT]) begin
        inbound_new_entry_status <= 1'b0;
      end
      if ((state == ST_IDLE) & pci_req & pci_write & ~pci_access_disable
          & queue_mode_enable & (pci_addr == `MQU_WIN_DBL)) begin
        doorbell_local_status <= 1'b1;
      end else if (apb_wr & (paddr == `MQU_REG_INTST) & pwdata[`MQU_INT_DBL_BIT]) begin
        doorbell_local_status <= 1'b0;
      end
      if ((state == ST_IDLE) & pci_req & pci_write & ~pci_access_disable
          & queue_mode_enable & (pci_addr == `MQU_WIN_DBP)) begin
        doorbell_pci_status <= 1'b1;
      end else if (apb_wr & (paddr == `MQU_REG_INTST) & pwdata[`MQU_INT_DBP_BIT]) begin
        doorbell_pci_status <= 1'b0;
      end
    end
  end

  // interrupt lines and configuration relocation, registered
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      local_irq <= 1'b0;
      pci_irq <= 1'b0;
      image0_at_first_bar <= 1'b0;
      register_bar_offset <= `MQU_CFG_BAR_FIRST;
    end else begin
      local_irq <= (inbound_new_entry_status & int_enable[`MQU_INT_IN_BIT])
                   | (doorbell_local_status & int_enable[`MQU_INT_DBL_BIT]);
      pci_irq <= (outbound_post_status & int_enable[`MQU_INT_OUT_BIT])
                 | (doorbell_pci_status & int_enable[`MQU_INT_DBP_BIT]);
      image0_at_first_bar <= queue_mode_enable;
      register_bar_offset <= queue_mode_enable ? `MQU_CFG_BAR_THIRD : `MQU_CFG_BAR_FIRST;
    end
  end

  // apb slave: data prepared in setup, zero-wait access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_setup;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (apb_setup) begin
        if (paddr >= `MQU_REG_PTR0 && paddr <= `MQU_REG_PTR_LAST && paddr[1:0] == 2'b00) begin
          // pointers read back with the shared base above them
          prdata <= {qba, ptr_flat[paddr[4:2]*20 +: 20]};
        end else begin
          case (paddr)
            `MQU_REG_CTRL: begin
              prdata <= {qba, 8'h00, full, empty, size_sel, queue_mode_enable};
            end
            `MQU_REG_MISC: begin
              prdata <= {31'h0000_0000, pci_access_disable};
            end
            `MQU_REG_INTEN: begin
              prdata <= {28'h000_0000, int_enable};
            end
            `MQU_REG_INTST: begin
              prdata <= {28'h000_0000, doorbell_pci_status, doorbell_local_status,
                         outbound_post_status, inbound_new_entry_status};
            end
            `MQU_REG_XLATE: begin
              prdata <= image0_translation;
            end
            default: begin
              pslverr <= 1'b1; // unmapped address
            end
          endcase
        end
      end
    end
  end

  // pci request sequencer
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (pci_req) begin
          next_state = ST_ACK;
          if (lb_req_start) begin
            next_state = ST_LBUS;
          end
        end
      end
      ST_LBUS: begin
        if (lb_ack) begin
          next_state = ST_ACK;
        end
      end
      ST_ACK: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // decode of one pci request: whether a local cycle is needed, where, and which pointer moves
  always @* begin
    lb_req_start = 1'b0;
    start_adv = 1'b0;
    start_idx = P_IF_BOT;
    start_addr = 32'h0000_0000;
    start_rdata = 32'h0000_0000;
    if (pci_access_disable | ~queue_mode_enable) begin
      start_rdata = `MQU_EMPTY_WORD; // window closed: reads float high, writes dropped
    end else if (pci_addr >= `MQU_WIN_UNTRANS) begin
      lb_req_start = 1'b1;
      start_addr = image0_translation + pci_addr;
    end else if (pci_addr == `MQU_WIN_INBOUND) begin
      if (pci_write) begin
        // a full queue drops the post rather than overwrite the oldest
        lb_req_start = ~full[Q_IP];
        start_adv = 1'b1;
        start_idx = P_IP_TOP;
        start_addr = {qba, ptr_flat[P_IP_TOP*20 +: 20]};
      end else begin
        lb_req_start = ~empty[Q_IF];
        start_adv = 1'b1;
        start_idx = P_IF_BOT;
        start_addr = {qba, ptr_flat[P_IF_BOT*20 +: 20]};
        start_rdata = `MQU_EMPTY_WORD;
      end
    end else if (pci_addr == `MQU_WIN_OUTBOUND) begin
      if (pci_write) begin
        lb_req_start = ~full[Q_OF];
        start_adv = 1'b1;
        start_idx = P_OF_TOP;
        start_addr = {qba, ptr_flat[P_OF_TOP*20 +: 20]};
      end else begin
        lb_req_start = ~empty[Q_OP];
        start_adv = 1'b1;
        start_idx = P_OP_BOT;
        start_addr = {qba, ptr_flat[P_OP_BOT*20 +: 20]};
        start_rdata = `MQU_EMPTY_WORD;
      end
    end
  end

  // sequencer registers and local-bus master
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      adv_pending <= 1'b0;
      adv_idx <= P_IF_BOT;
      lb_req <= 1'b0;
      lb_write <= 1'b0;
      lb_addr <= 32'h0000_0000;
      lb_wdata <= 32'h0000_0000;
      pci_ack <= 1'b0;
      pci_rdata <= 32'h0000_0000;
    end else begin
      state <= next_state;
      pci_ack <= (next_state == ST_ACK);
      if (state == ST_IDLE && pci_req) begin
        adv_pending <= start_adv & lb_req_start;
        adv_idx <= start_idx;
        lb_req <= lb_req_start;
        lb_write <= pci_write;
        lb_addr <= start_addr;
        lb_wdata <= pci_wdata;
        pci_rdata <= pci_write ? 32'h0000_0000 : start_rdata;
      end else if (state == ST_LBUS && lb_ack) begin
        // frame address or data handed back as the local bus returned it
        lb_req <= 1'b0;
        adv_pending <= 1'b0;
        pci_rdata <= lb_write ? 32'h0000_0000 : lb_rdata;
      end
    end
  end
endmodule // mqu_top
`default_nettype wire

// *** test/mqu_top_assertions.sv ***
// port checks for the message queue unit, bound into mqu_top
// assumes one clock pclk and asynchronous active-low presetn
`timescale 1ns/1ps
`default_nettype none
module mqu_top_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pci_req,
  input wire logic [31:0] pci_addr,
  input wire logic [31:0] pci_wdata,
  input wire logic pci_ack,
  input wire logic [31:0] pci_rdata,
  input wire logic lb_req,
  input wire logic lb_write,
  input wire logic [31:0] lb_addr,
  input wire logic [31:0] lb_wdata,
  input wire logic lb_ack,
  input wire logic [31:0] lb_rdata,
  input wire logic pci_irq,
  input wire logic image0_at_first_bar,
  input wire logic [7:0] register_bar_offset
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_apb_answer: assert property (psel && !penable |=> pready)
    else $error("apb setup not answered");
  chk_bar_move: assert property (
    register_bar_offset == (image0_at_first_bar ? 8'h18 : 8'h10))
    else $error("register base offset wrong");
  chk_ack_after_lb: assert property (lb_req && lb_ack |=> pci_ack && !lb_req)
    else $error("no ack after local cycle");
  chk_read_pass: assert property (
    lb_req && lb_ack && !lb_write |=> pci_rdata == $past(lb_rdata))
    else $error("read data not passed on");
  chk_lb_hold: assert property (
    lb_req && !lb_ack |=> lb_req && $stable(lb_addr) && $stable(lb_write))
    else $error("local request changed early");
  chk_lb_aligned: assert property (
    lb_req && pci_addr < 32'h0000_1000 |-> lb_addr[1:0] == 2'b00)
    else $error("queue address not word aligned");
  chk_post_data: assert property (
    lb_req && lb_write && pci_req |-> lb_wdata == pci_wdata)
    else $error("posted word differs");
  chk_ack_pulse: assert property (pci_ack |=> !pci_ack)
    else $error("ack longer than one cycle");
  chk_ack_bound: assert property ($rose(pci_req) |-> ##[1:40] pci_ack)
    else $error("pci request not acked");

  // main traffic kinds
  cov_lb_read: cover property (lb_req && lb_ack && !lb_write);
  cov_lb_write: cover property (lb_req && lb_ack && lb_write);
  cov_pci_irq: cover property ($rose(pci_irq));
endmodule // mqu_top_assertions

bind mqu_top mqu_top_assertions i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pci_req(pci_req), .pci_addr(pci_addr),
  .pci_wdata(pci_wdata), .pci_ack(pci_ack), .pci_rdata(pci_rdata), .lb_req(lb_req),
  .lb_write(lb_write), .lb_addr(lb_addr), .lb_wdata(lb_wdata), .lb_ack(lb_ack),
  .lb_rdata(lb_rdata), .pci_irq(pci_irq), .image0_at_first_bar(image0_at_first_bar),
  .register_bar_offset(register_bar_offset));
`default_nettype wire

// *** test/mqu_lb_model.sv ***
// local-bus memory model holding the four queues and message frames
// assumes requests held until lb_ack, same clock as the unit
`timescale 1ns/1ps
`default_nettype none
module mqu_lb_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic lb_req,
  input wire logic lb_write,
  input wire logic [31:0] lb_addr,
  input wire logic [31:0] lb_wdata,
  input wire logic [3:0] lat,
  output logic lb_ack,
  output logic [31:0] lb_rdata
);
  logic [31:0] mem [logic [31:0]];
  logic [3:0] cnt;
  // answer after lat waits; idle data toggles so a stale word never passes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lb_ack <= 1'b0;
      cnt <= 4'h0;
      lb_rdata <= 32'h0;
    end else if (lb_req && !lb_ack && cnt >= lat) begin
      lb_ack <= 1'b1;
      cnt <= 4'h0;
      if (lb_write)
        mem[lb_addr] = lb_wdata;
      lb_rdata <= mem.exists(lb_addr) ? mem[lb_addr] : 32'h5A5A_5A5A;
    end else begin
      lb_ack <= 1'b0;
      cnt <= (lb_req && !lb_ack) ? cnt + 4'h1 : 4'h0;
      lb_rdata <= ~lb_rdata;
    end
  end
endmodule // mqu_lb_model
`default_nettype wire

// *** test/test_message_queue_unit.sv ***
// self-checking bench for the message queue unit: apb master, pci port driver
// assumes the local-bus memory model answers every lb_req
`timescale 1ns/1ps
`default_nettype none
`include "mqu_consts.vh"
module test_message_queue_unit;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic pci_req = 1'b0, pci_write = 1'b0, perr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, pci_addr = 32'h0, pci_wdata = 32'h0, q;
  logic [3:0] lat = 4'h0;
  logic [31:0] prdata, pci_rdata, lb_addr, lb_wdata, lb_rdata;
  logic pready, pslverr, pci_ack, lb_req, lb_write, lb_ack, local_irq, pci_irq;
  logic image0_at_first_bar;
  logic [7:0] register_bar_offset;
  logic [19:0] ptr0 [8] = '{20'h0, 20'h8, 20'h400, 20'h400, 20'h800, 20'h800, 20'hC00, 20'hC00};
  int err_total = 0, checks_done = 0;

  mqu_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pci_req(pci_req), .pci_write(pci_write), .pci_addr(pci_addr),
    .pci_wdata(pci_wdata), .pci_ack(pci_ack), .pci_rdata(pci_rdata), .lb_req(lb_req),
    .lb_write(lb_write), .lb_addr(lb_addr), .lb_wdata(lb_wdata), .lb_ack(lb_ack),
    .lb_rdata(lb_rdata), .local_irq(local_irq), .pci_irq(pci_irq),
    .image0_at_first_bar(image0_at_first_bar), .register_bar_offset(register_bar_offset));
  mqu_lb_model i_lb (.pclk(pclk), .presetn(presetn), .lb_req(lb_req), .lb_write(lb_write),
    .lb_addr(lb_addr), .lb_wdata(lb_wdata), .lat(lat), .lb_ack(lb_ack), .lb_rdata(lb_rdata));

  // 125 MHz
  always #4 pclk = ~pclk;

  task finish_test;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task tmo;
    err_total++;
    $display("[ERR] %0t wait ran out", $time);
    finish_test;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // apb transfer; entered just after an edge, held until pready is sampled
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge, so a following call never re-raises psel in this time step
    @(posedge pclk);
    if (n >= 50)
      tmo;
  endtask

  // pci port request, level held until the ack is sampled
  task pci(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    pci_req <= 1'b1;
    pci_write <= w;
    pci_addr <= a;
    pci_wdata <= d;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pci_ack !== 1'b1 && n < 50);
    q = pci_rdata;
    pci_req <= 1'b0;
    // idle edge between requests, the request must be seen low once
    @(posedge pclk);
    if (n >= 50)
      tmo;
  endtask

  task t_reset;
    apb(0, `MQU_REG_MISC, 32'h0);
    chk(q[0], 1'b1);
    chk(register_bar_offset, 8'h10);
    pci(0, `MQU_WIN_INBOUND, 32'h0);
    chk(q, `MQU_EMPTY_WORD);
    apb(0, 12'h018, 32'h0);
    chk(perr, 1'b1);
    chk(q, 32'h0);
    $display("reset test end");
  endtask

  task t_setup;
    i_lb.mem[32'hA000_0000] = 32'h0000_2000;
    i_lb.mem[32'hA000_0004] = 32'h0000_3000;
    apb(1, `MQU_REG_CTRL, 32'hA000_0000);
    // pointers before enabling queue mode
    for (int k = 0; k < 8; k++)
      apb(1, 12'(`MQU_REG_PTR0 + 4 * k), {12'h000, ptr0[k]});
    for (int k = 0; k < 8; k++) begin
      apb(0, 12'(`MQU_REG_PTR0 + 4 * k), 32'h0);
      chk(q, {12'hA00, ptr0[k]});
    end
    apb(1, `MQU_REG_CTRL, 32'hA000_0001);
    apb(1, `MQU_REG_MISC, 32'h0);
    apb(0, `MQU_REG_CTRL, 32'h0);
    chk(q[11:0], 12'h0E1);
    chk(register_bar_offset, 8'h18);
    chk(image0_at_first_bar, 1'b1);
    $display("setup test end");
  endtask

  task t_in;
    apb(1, `MQU_REG_INTEN, 32'h1);
    pci(0, `MQU_WIN_INBOUND, 32'h0);
    chk(q, 32'h2000);
    lat <= 4'h3;
    pci(0, `MQU_WIN_INBOUND, 32'h0);
    chk(q, 32'h3000);
    pci(0, `MQU_WIN_INBOUND, 32'h0);
    chk(q, `MQU_EMPTY_WORD);
    apb(0, 12'h020, 32'h0);
    chk(q, 32'hA000_0008);
    pci(1, `MQU_WIN_INBOUND, 32'h2000);
    chk(i_lb.mem[32'hA000_0400], 32'h2000);
    apb(0, 12'h02C, 32'h0);
    chk(q, 32'hA000_0404);
    chk(local_irq, 1'b1);
    apb(1, `MQU_REG_INTST, 32'h1);
    apb(0, `MQU_REG_INTST, 32'h0);
    chk(q[0], 1'b0);
    chk(local_irq, 1'b0);
    $display("inbound test end");
  endtask

  task t_out;
    apb(1, `MQU_REG_INTEN, 32'h2);
    i_lb.mem[32'hA000_0800] = 32'h1234_5000;
    apb(1, 12'h034, 32'h804);
    apb(0, `MQU_REG_INTST, 32'h0);
    chk(q[1], 1'b1);
    chk(pci_irq, 1'b1);
    pci(0, `MQU_WIN_OUTBOUND, 32'h0);
    chk(q, 32'h1234_5000);
    apb(0, `MQU_REG_INTST, 32'h0);
    chk(q[1], 1'b0);
    chk(pci_irq, 1'b0);
    pci(0, `MQU_WIN_OUTBOUND, 32'h0);
    chk(q, `MQU_EMPTY_WORD);
    $display("outbound test end");
  endtask

  task t_wrap;
    apb(1, 12'h03C, 32'hFFC);
    apb(1, 12'h038, 32'hC04);
    pci(1, `MQU_WIN_OUTBOUND, 32'h0000_7000);
    chk(i_lb.mem[32'hA000_0FFC], 32'h7000);
    apb(0, 12'h03C, 32'h0);
    chk(q, 32'hA000_0C00);
    pci(1, `MQU_WIN_OUTBOUND, 32'h0000_7100);
    apb(0, `MQU_REG_CTRL, 32'h0);
    chk(q[11], 1'b1);
    pci(1, `MQU_WIN_OUTBOUND, 32'h0000_7200);
    chk(i_lb.mem.exists(32'hA000_0C04), 1'b0);
    apb(0, 12'h03C, 32'h0);
    chk(q, 32'hA000_0C04);
    // in_post marked full: top to its upper end, then one step on, onto the bottom
    apb(1, 12'h02C, 32'h7FC);
    apb(1, 12'h02C, 32'h400);
    apb(0, `MQU_REG_CTRL, 32'h0);
    chk(q[9], 1'b1);
    chk(q[5], 1'b0);
    pci(1, `MQU_WIN_INBOUND, 32'h0000_9900);
    chk(i_lb.mem[32'hA000_0400], 32'h2000);
    $display("wrap test end");
  endtask

  task t_win;
    apb(1, `MQU_REG_XLATE, 32'h4000_0000);
    pci(1, 32'h0000_2000, 32'h55AA_33CC);
    chk(i_lb.mem[32'h4000_2000], 32'h55AA_33CC);
    pci(0, 32'h0000_2000, 32'h0);
    chk(q, 32'h55AA_33CC);
    pci(0, 32'h0000_0FF0, 32'h0);
    chk(q, 32'h0);
    apb(1, `MQU_REG_INTEN, 32'hC);
    pci(1, `MQU_WIN_DBL, 32'h1);
    pci(1, `MQU_WIN_DBP, 32'h1);
    apb(0, `MQU_REG_INTST, 32'h0);
    chk(q[3:2], 2'b11);
    chk(local_irq, 1'b1);
    chk(pci_irq, 1'b1);
    $display("window test end");
  endtask

  // reset held ten cycles, then scenarios in order
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_setup;
    t_in;
    t_out;
    t_wrap;
    t_win;
    finish_test;
  end
endmodule // test_message_queue_unit
`default_nettype wire
